/* File: src/sffrp_defs.svh */
// constants of the serial flash fast read path
`ifndef SFFRP_DEFS_SVH
`define SFFRP_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFFRP_OP_FAST       8'h0B
`define SFFRP_OP_FAST4      8'h0C
`define SFFRP_OP_DOUT       8'h3B
`define SFFRP_OP_DOUT4      8'h3C
`define SFFRP_OP_QOUT       8'h6B
`define SFFRP_OP_QOUT4      8'h6C
`define SFFRP_OP_DIO        8'hBB
`define SFFRP_OP_DIO4       8'hBC
`define SFFRP_OP_QIO        8'hEB
`define SFFRP_OP_QIO4       8'hEC
`define SFFRP_OP_DTR        8'hED
`define SFFRP_OP_DTR4       8'hEE

// ----------------------------------------------------------------
// field counts and values
// ----------------------------------------------------------------
`define SFFRP_CMD_BITS      6'h08
`define SFFRP_ADDR_BITS3    6'h18
`define SFFRP_ADDR_BITS4    6'h20
`define SFFRP_BYTE_BITS     4'h8
`define SFFRP_DUMMY_SDR     4'h8
`define SFFRP_DUMMY_QIO     4'h4
`define SFFRP_DUMMY_DTR     4'h6
`define SFFRP_CONT_PAIR     2'h2
`define SFFRP_WRAP_RESET    3'h1
`define SFFRP_WRAP_DIS_BIT  0
`define SFFRP_WRAP_MIN      32'h0000_0008
`define SFFRP_ADDR_ONE      32'h0000_0001
`define SFFRP_LG_1          2'h0
`define SFFRP_LG_2          2'h1
`define SFFRP_LG_4          2'h2

// ----------------------------------------------------------------
// data buffer
// ----------------------------------------------------------------
`define SFFRP_BUF_WIDTH     8
`define SFFRP_BUF_DEPTH     2

`endif

/* File: src/sffrp_pkg.sv */
// types shared by the serial flash fast read path
package sffrp_pkg;

  // ----------------------------------------------------------------
  // transaction states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sffrp_state_t;

  // ----------------------------------------------------------------
  // decoded read command; lane widths held as log2 of lines
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       addr4;
    logic [1:0] addrLg;
    logic [1:0] dataLg;
    logic       hasMode;
    logic [3:0] dummyClk;
    logic       dtr;
    logic       wrapOk;
  } sffrp_cmd_t;

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sffrp_pins_t;

endpackage

/* File: src/sffrp_fifo2.sv */
// two-entry data buffer between memory fetch and serial output
`timescale 1ns/10ps
`include "sffrp_defs.svh"
module sffrp_fifo2 #(
  parameter int WIDTH = `SFFRP_BUF_WIDTH,
  parameter int DEPTH = `SFFRP_BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    wrPtr_next;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW-1:0]    rdPtr_next;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;
  logic             inReady_reg;
  logic             inReady_next;
  logic             push;
  logic             pop;

  assign inReady  = inReady_reg;
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    push       = inValid & inReady_reg;
    pop        = outReady & outValid;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (push) begin
      mem_next[wrPtr_reg] = inData;
      wrPtr_next = (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
    end
    if (pop) begin
      rdPtr_next = (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    // a flush drops anything buffered, including a word pushed now
    if (flush) begin
      wrPtr_next = '0;
      rdPtr_next = '0;
      count_next = '0;
    end
    // ready is registered so the memory side sees a clean level
    inReady_next = (count_next != FULL);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg   <= '0;
      rdPtr_reg   <= '0;
      count_reg   <= '0;
      inReady_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wrPtr_reg   <= wrPtr_next;
      rdPtr_reg   <= rdPtr_next;
      count_reg   <= count_next;
      inReady_reg <= inReady_next;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

endmodule

/* File: src/sffrp_core.sv */
// read command path of a serial flash, sampled on the system clock
`timescale 1ns/10ps
`include "sffrp_defs.svh"
module sffrp_core
  import sffrp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sclkPin,
  input  wire logic        csnPin,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe,
  input  wire logic        fourByteMode,
  input  wire logic        writeBusy,
  input  wire logic        resetCmd,
  input  wire logic        wrapLoad,
  input  wire logic [2:0]  wrapCfgIn,
  output logic      [2:0]  wrapCfg,
  output logic             contReadActive,
  output logic             memReqValid,
  input  wire logic        memReqReady,
  output logic      [31:0] memReqAddr,
  input  wire logic        memRspValid,
  output logic             memRspReady,
  input  wire logic [7:0]  memRspData
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic sffrp_cmd_t decodeOp(input logic [7:0] op);
    sffrp_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.addr4 = (op == `SFFRP_OP_FAST4) | (op == `SFFRP_OP_DOUT4) |
              (op == `SFFRP_OP_QOUT4) | (op == `SFFRP_OP_DIO4)  |
              (op == `SFFRP_OP_QIO4)  | (op == `SFFRP_OP_DTR4);
    case (op)
      `SFFRP_OP_FAST, `SFFRP_OP_FAST4: begin
        c.dummyClk = `SFFRP_DUMMY_SDR;
      end
      `SFFRP_OP_DOUT, `SFFRP_OP_DOUT4: begin
        c.dummyClk = `SFFRP_DUMMY_SDR;
        c.dataLg   = `SFFRP_LG_2;
      end
      `SFFRP_OP_QOUT, `SFFRP_OP_QOUT4: begin
        c.dummyClk = `SFFRP_DUMMY_SDR;
        c.dataLg   = `SFFRP_LG_4;
      end
      `SFFRP_OP_DIO, `SFFRP_OP_DIO4: begin
        c.addrLg  = `SFFRP_LG_2;
        c.dataLg  = `SFFRP_LG_2;
        c.hasMode = 1'b1;
      end
      `SFFRP_OP_QIO, `SFFRP_OP_QIO4: begin
        c.addrLg   = `SFFRP_LG_4;
        c.dataLg   = `SFFRP_LG_4;
        c.hasMode  = 1'b1;
        c.dummyClk = `SFFRP_DUMMY_QIO;
        c.wrapOk   = 1'b1;
      end
      `SFFRP_OP_DTR, `SFFRP_OP_DTR4: begin
        c.addrLg   = `SFFRP_LG_4;
        c.dataLg   = `SFFRP_LG_4;
        c.hasMode  = 1'b1;
        c.dummyClk = `SFFRP_DUMMY_DTR;
        c.dtr      = 1'b1;
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction

  // edges of the address phase for one command
  function automatic logic [5:0] addrEdges(input sffrp_cmd_t c,
                                           input logic fb);
    logic [5:0] bits;
    bits = (c.addr4 | fb) ? `SFFRP_ADDR_BITS4 : `SFFRP_ADDR_BITS3;
    return bits >> c.addrLg;
  endfunction

  // line 3 holds the top bit of each nibble, line 0 the bottom
  function automatic logic [31:0] shiftIn(input logic [31:0] v,
                                          input logic [1:0]  lg,
                                          input logic [3:0]  io);
    case (lg)
      `SFFRP_LG_1: return {v[30:0], io[0]};
      `SFFRP_LG_2: return {v[29:0], io[1:0]};
      default:     return {v[27:0], io[3:0]};
    endcase
  endfunction

  // the top bits of a byte onto the lines of the data width
  function automatic sffrp_pins_t lanes(input logic [1:0] lg,
                                        input logic [7:0] b);
    sffrp_pins_t p;
    p = '0;
    case (lg)
      `SFFRP_LG_1: begin
        p.out[1] = b[7];
        p.oe     = 4'h2;
      end
      `SFFRP_LG_2: begin
        p.out[1:0] = b[7:6];
        p.oe       = 4'h3;
      end
      default: begin
        p.out = b[7:4];
        p.oe  = 4'hF;
      end
    endcase
    return p;
  endfunction

  // next read address: plain increment, or wrap inside a section
  function automatic logic [31:0] nextAddr(input logic [31:0] a,
                                           input logic        wrapOk,
                                           input logic [2:0]  cfg);
    logic [31:0] mask;
    logic [31:0] inc;
    mask = (`SFFRP_WRAP_MIN << cfg[2:1]) - `SFFRP_ADDR_ONE;
    inc  = a + `SFFRP_ADDR_ONE;
    if (wrapOk && !cfg[`SFFRP_WRAP_DIS_BIT]) begin
      return (a & ~mask) | (inc & mask);
    end
    return inc;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and link clock edges
  // ----------------------------------------------------------------
  logic       sclkS1;
  logic       sclkS2;
  logic       sclkS3;
  logic       csnS1;
  logic       csnS2;
  logic [3:0] ioS1;
  logic [3:0] ioS2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
      csnS1  <= 1'b1;
      csnS2  <= 1'b1;
      ioS1   <= 4'h0;
      ioS2   <= 4'h0;
    end else begin
      sclkS1 <= sclkPin;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      csnS1  <= csnPin;
      csnS2  <= csnS1;
      ioS1   <= ioIn;
      ioS2   <= ioS1;
    end
  end

  logic rise;
  logic fall;
  assign rise = sclkS2 & ~sclkS3;
  assign fall = ~sclkS2 & sclkS3;

  // ----------------------------------------------------------------
  // transaction state
  // ----------------------------------------------------------------
  sffrp_state_t state_reg, state_next;
  sffrp_cmd_t   cmd_reg, cmd_next;
  sffrp_cmd_t   contCmd_reg, contCmd_next;
  sffrp_cmd_t   dc;
  sffrp_pins_t  pins_reg, pins_next;
  logic [5:0]   cnt_reg, cnt_next;
  logic [3:0]   outCnt_reg, outCnt_next;
  logic [7:0]   shift_reg, shift_next;
  logic [31:0]  addr_reg, addr_next;
  logic [31:0]  fetchAddr_reg, fetchAddr_next;
  logic [31:0]  reqAddr_reg, reqAddr_next;
  logic [31:0]  sh;
  logic [2:0]   wrapCfg_reg, wrapCfg_next;
  logic         contMode_reg, contMode_next;
  logic         fetchEn_reg, fetchEn_next;
  logic         reqValid_reg, reqValid_next;
  logic         inflight_reg, inflight_next;
  logic         drop_reg, drop_next;
  logic         sampleEdge;
  logic         launchEdge;
  logic         flush;
  logic         pop;
  logic         rspAccept;
  logic         bufInReady;
  logic         bufOutValid;
  logic [7:0]   bufOutData;

  assign rspAccept = memRspValid & bufInReady;

  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    contCmd_next   = contCmd_reg;
    pins_next      = pins_reg;
    cnt_next       = cnt_reg;
    outCnt_next    = outCnt_reg;
    shift_next     = shift_reg;
    addr_next      = addr_reg;
    fetchAddr_next = fetchAddr_reg;
    reqAddr_next   = reqAddr_reg;
    wrapCfg_next   = wrapCfg_reg;
    contMode_next  = contMode_reg;
    fetchEn_next   = fetchEn_reg;
    reqValid_next  = reqValid_reg;
    inflight_next  = inflight_reg;
    drop_next      = drop_reg;
    flush          = 1'b0;
    pop            = 1'b0;
    dc             = '0;
    sh             = shiftIn(addr_reg, cmd_reg.addrLg, ioS2);
    // double rate moves address, mode and dummy on both edges
    sampleEdge = rise | (cmd_reg.dtr & fall);
    launchEdge = fall | (cmd_reg.dtr & rise);
    if (wrapLoad) begin
      wrapCfg_next = wrapCfgIn;
    end
    if (resetCmd) begin
      contMode_next = 1'b0;
    end
    if (csnS2) begin
      state_next   = ST_IDLE;
      pins_next    = '0;
      fetchEn_next = 1'b0;
      flush        = 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          addr_next = '0;
          if (contMode_reg) begin
            cmd_next   = contCmd_reg;
            cnt_next   = addrEdges(contCmd_reg, fourByteMode);
            state_next = ST_ADDR;
          end else begin
            cnt_next   = `SFFRP_CMD_BITS;
            state_next = ST_CMD;
          end
        end
        ST_CMD: begin
          if (rise) begin
            shift_next = {shift_reg[6:0], ioS2[0]};
            cnt_next   = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              dc = decodeOp({shift_reg[6:0], ioS2[0]});
              if (!dc.valid || (dc.dtr && writeBusy)) begin
                state_next = ST_IGNORE;
              end else begin
                cmd_next   = dc;
                cnt_next   = addrEdges(dc, fourByteMode);
                state_next = ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (sampleEdge) begin
            addr_next = sh;
            cnt_next  = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              fetchAddr_next = sh;
              fetchEn_next   = 1'b1;
              if (cmd_reg.hasMode) begin
                cnt_next   = {2'h0, `SFFRP_BYTE_BITS >> cmd_reg.addrLg};
                state_next = ST_MODE;
              end else begin
                cnt_next   = {2'h0, cmd_reg.dummyClk};
                state_next = ST_DUMMY;
              end
            end
          end
        end
        ST_MODE: begin
          if (sampleEdge) begin
            dc.dummyClk = cmd_reg.dummyClk;
            sh          = shiftIn({24'h0, shift_reg}, cmd_reg.addrLg,
                                  ioS2);
            shift_next  = sh[7:0];
            cnt_next    = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              // pair 10 keeps the command for the next selection
              contMode_next = (shift_next[5:4] == `SFFRP_CONT_PAIR);
              contCmd_next  = cmd_reg;
              outCnt_next   = 4'h0;
              if (cmd_reg.dummyClk == 4'h0) begin
                state_next = ST_DATA;
              end else begin
                cnt_next   = cmd_reg.dtr ? {1'b0, cmd_reg.dummyClk, 1'b0}
                                         : {2'h0, cmd_reg.dummyClk};
                state_next = ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          pins_next = '0;
          if (sampleEdge) begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              outCnt_next = 4'h0;
              state_next  = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (launchEdge) begin
            if (outCnt_reg == 4'h0) begin
              if (bufOutValid) begin
                pop         = 1'b1;
                pins_next   = lanes(cmd_reg.dataLg, bufOutData);
                shift_next  = bufOutData << (4'h1 << cmd_reg.dataLg);
                outCnt_next = (`SFFRP_BYTE_BITS >> cmd_reg.dataLg) - 4'h1;
              end
            end else begin
              pins_next   = lanes(cmd_reg.dataLg, shift_reg);
              shift_next  = shift_reg << (4'h1 << cmd_reg.dataLg);
              outCnt_next = outCnt_reg - 4'h1;
            end
          end
        end
        ST_IGNORE: begin
          pins_next = '0;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    // one fetch in flight at a time, ahead of the serial output
    if (fetchEn_reg && !csnS2 && !reqValid_reg && !inflight_reg &&
        !drop_reg && bufInReady) begin
      reqValid_next  = 1'b1;
      reqAddr_next   = fetchAddr_reg;
      fetchAddr_next = nextAddr(fetchAddr_reg, cmd_reg.wrapOk,
                                wrapCfg_reg);
    end
    if (reqValid_reg && memReqReady) begin
      reqValid_next = 1'b0;
      inflight_next = 1'b1;
    end
    if (inflight_reg && rspAccept) begin
      inflight_next = 1'b0;
      drop_next     = 1'b0;
    end
    // a fetch still open at deselect returns stale data; discard it
    if (csnS2 && (reqValid_reg || (inflight_reg && !rspAccept))) begin
      drop_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ST_IDLE;
      cmd_reg       <= '0;
      contCmd_reg   <= '0;
      pins_reg      <= '0;
      cnt_reg       <= 6'h00;
      outCnt_reg    <= 4'h0;
      shift_reg     <= 8'h00;
      addr_reg      <= 32'h0000_0000;
      fetchAddr_reg <= 32'h0000_0000;
      reqAddr_reg   <= 32'h0000_0000;
      wrapCfg_reg   <= `SFFRP_WRAP_RESET;
      contMode_reg  <= 1'b0;
      fetchEn_reg   <= 1'b0;
      reqValid_reg  <= 1'b0;
      inflight_reg  <= 1'b0;
      drop_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      contCmd_reg   <= contCmd_next;
      pins_reg      <= pins_next;
      cnt_reg       <= cnt_next;
      outCnt_reg    <= outCnt_next;
      shift_reg     <= shift_next;
      addr_reg      <= addr_next;
      fetchAddr_reg <= fetchAddr_next;
      reqAddr_reg   <= reqAddr_next;
      wrapCfg_reg   <= wrapCfg_next;
      contMode_reg  <= contMode_next;
      fetchEn_reg   <= fetchEn_next;
      reqValid_reg  <= reqValid_next;
      inflight_reg  <= inflight_next;
      drop_reg      <= drop_next;
    end
  end

  // ----------------------------------------------------------------
  // data buffer
  // ----------------------------------------------------------------
  sffrp_fifo2 u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (flush),
    .inValid  (memRspValid & ~drop_reg),
    .inReady  (bufInReady),
    .inData   (memRspData),
    .outValid (bufOutValid),
    .outReady (pop),
    .outData  (bufOutData)
  );

  assign ioOut          = pins_reg.out;
  assign ioOe           = pins_reg.oe;
  assign wrapCfg        = wrapCfg_reg;
  assign contReadActive = contMode_reg;
  assign memReqValid    = reqValid_reg;
  assign memReqAddr     = reqAddr_reg;
  assign memRspReady    = bufInReady;

endmodule

/* File: dv/sffrp_core_props.sv */
// port assertions of the serial flash read path
`timescale 1ns/10ps
module sffrp_core_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        csnPin,
  input wire logic [3:0]  ioOe,
  input wire logic        resetCmd,
  input wire logic        wrapLoad,
  input wire logic [2:0]  wrapCfgIn,
  input wire logic [2:0]  wrapCfg,
  input wire logic        contReadActive,
  input wire logic        memReqValid,
  input wire logic        memReqReady,
  input wire logic [31:0] memReqAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // six cycles covers the pin synchroniser plus the release delay
  sequence csIdle;
    csnPin [*6];
  endsequence
  sequence ctlQuiet;
    (csnPin && !resetCmd) [*4];
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_WRAP_LOAD: assert property (
    wrapLoad |=> wrapCfg == $past(wrapCfgIn)) else $error("wrap not loaded");
  AST_WRAP_KEEP: assert property (
    !wrapLoad |=> $stable(wrapCfg)) else $error("wrap setting changed");
  AST_CS_FREE: assert property (
    csIdle |-> ioOe == 4'h0) else $error("lines driven while deselected");
  AST_OE_LEGAL: assert property (
    ioOe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad line enables");
  AST_REQ_HOLD: assert property (
    memReqValid && !memReqReady |=> memReqValid && $stable(memReqAddr))
    else $error("fetch request dropped");
  AST_REQ_ONE: assert property (
    memReqValid && memReqReady |=> !memReqValid) else $error("fetch repeated");
  AST_RST_CMD: assert property (
    csnPin && resetCmd |=> !contReadActive) else $error("mode not cleared");
  AST_CONT_KEEP: assert property (
    ctlQuiet |=> $stable(contReadActive)) else $error("mode changed idle");
endmodule
bind sffrp_core sffrp_core_props i_sffrp_core_props (
  .clk(clk), .rstn(rstn), .csnPin(csnPin), .ioOe(ioOe),
  .resetCmd(resetCmd), .wrapLoad(wrapLoad), .wrapCfgIn(wrapCfgIn),
  .wrapCfg(wrapCfg), .contReadActive(contReadActive),
  .memReqValid(memReqValid), .memReqReady(memReqReady),
  .memReqAddr(memReqAddr));

/* File: dv/sffrp_host_model.sv */
// serial host that drives the read path's pins
`timescale 1ns/10ps
module sffrp_host_model (
  output logic            sclkPin,
  output logic            csnPin,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  logic [3:0] hostV, hostOe, seenOe, dumOe, smp;
  logic [7:0] rd [$];
  // a released line shows the inverse of the last host value
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostOe & hostV)
              | (~ioOe & ~hostOe & ~hostV);
  initial begin
    sclkPin = 0;
    csnPin = 1;
    hostV = 4'h0;
    hostOe = 4'h0;
  end
  // one clock: drive after fall, sample just before rise
  task cyc(input logic [3:0] v, input logic [3:0] m);
    sclkPin = 0;
    hostV = v;
    hostOe = m;
    #80;
    smp = ioIn;
    seenOe = seenOe | ioOe;
    sclkPin = 1;
    #80;
  endtask
  task sendv(input logic [31:0] v, input int nb, input int lg);
    logic [3:0] m;
    m = 4'((1 << (1 << lg)) - 1);
    for (int i = nb - (1 << lg); i >= 0; i -= (1 << lg))
      cyc(4'(v >> i) & m, m);
  endtask
  task frame(input logic [7:0] op, input logic sendOp,
             input logic [31:0] a, input int ab, input int lg,
             input logic hasMode, input logic [7:0] md,
             input int dum, input int dlg, input int n);
    logic [7:0] b;
    seenOe = 4'h0;
    rd.delete();
    csnPin = 0;
    #80;
    if (sendOp) sendv(32'(op), 8, 0);
    sendv(a, ab, lg);
    if (hasMode) sendv(32'(md), 8, lg);
    repeat (dum) cyc(hostV, 4'h0);
    dumOe = seenOe;
    repeat (n) begin
      for (int k = 0; k < 8; k += (1 << dlg)) begin
        cyc(hostV, 4'h0);
        b = dlg == 0 ? {b[6:0], smp[1]} :
            dlg == 1 ? {b[5:0], smp[1:0]} : {b[3:0], smp};
      end
      rd.push_back(b);
    end
    sclkPin = 0;
    #80;
    csnPin = 1;
    #160;
  endtask
endmodule

/* File: dv/sffrp_core_test.sv */
// self-checking bench of the serial flash read path
`timescale 1ns/10ps
`include "sffrp_defs.svh"
module sffrp_core_test;
  logic        clk, rstn, fourByteMode, writeBusy, resetCmd, wrapLoad;
  logic [2:0]  wrapCfgIn, wrapCfg;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic        sclkPin, csnPin, contReadActive, memReqValid, memReqReady;
  logic        memRspValid, memRspReady;
  logic [31:0] memReqAddr;
  logic [7:0]  memRspData;
  int          fails, checked;
  sffrp_core i_sffrp_core (.clk(clk), .rstn(rstn), .sclkPin(sclkPin),
    .csnPin(csnPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .fourByteMode(fourByteMode), .writeBusy(writeBusy),
    .resetCmd(resetCmd), .wrapLoad(wrapLoad), .wrapCfgIn(wrapCfgIn),
    .wrapCfg(wrapCfg), .contReadActive(contReadActive),
    .memReqValid(memReqValid), .memReqReady(memReqReady),
    .memReqAddr(memReqAddr), .memRspValid(memRspValid),
    .memRspReady(memRspReady), .memRspData(memRspData));
  sffrp_host_model i_sffrp_host_model (.sclkPin(sclkPin),
    .csnPin(csnPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[31:24] ^ 8'h5A;
  endfunction
  // memory: stalls every other request cycle, one fetch outstanding
  always @(posedge clk) begin
    if (memReqValid && memReqReady) begin
      memRspValid <= #1 1;
      memRspData <= #1 pat(memReqAddr);
    end else if (memRspValid && memRspReady)
      memRspValid <= #1 0;
    memReqReady <= #1 ~memReqReady;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkSeq(input logic [31:0] a);
    for (int k = 0; k < i_sffrp_host_model.rd.size(); k++)
      chk("data", pat(a + k), i_sffrp_host_model.rd[k]);
  endtask
  task automatic t_outs;
    logic [7:0] ops [4] = '{`SFFRP_OP_FAST, `SFFRP_OP_DOUT4,
                            `SFFRP_OP_QOUT, `SFFRP_OP_FAST};
    int lg [4] = '{0, 1, 2, 0};
    for (int j = 0; j < 4; j++) begin
      @(posedge clk) #1 fourByteMode = j == 3;
      i_sffrp_host_model.frame(ops[j], 1, 32'hAB0012FE, j % 2 ? 32 : 24,
                               0, 0, 8'h00, 8, lg[j], 3);
      chkSeq(j % 2 ? 32'hAB0012FE : 32'h12FE);
      chk("dummy oe", 8'h00, {4'h0, i_sffrp_host_model.dumOe});
    end
    @(posedge clk) #1 fourByteMode = 0;
  endtask
  task t_dio;
    i_sffrp_host_model.frame(`SFFRP_OP_DIO, 1, 32'h3400, 24, 1, 1,
                             8'h20, 0, 1, 2);
    chkSeq(32'h3400);
    chk("cont", 8'h01, {7'h0, contReadActive});
    i_sffrp_host_model.frame(8'h00, 0, 32'h5600, 24, 1, 1, 8'h00, 0, 1, 2);
    chkSeq(32'h5600);
    chk("cont", 8'h00, {7'h0, contReadActive});
  endtask
  task t_qio;
    logic [31:0] a;
    chk("wrap", 8'h01, {5'h0, wrapCfg});
    for (int j = 0; j < 2; j++) begin
      a = j ? 32'h13E : 32'h106;
      @(posedge clk) #1 wrapCfgIn = j ? 3'h6 : 3'h0;
      wrapLoad = 1;
      @(posedge clk) #1 wrapLoad = 0;
      chk("wrap", {5'h0, wrapCfgIn}, {5'h0, wrapCfg});
      i_sffrp_host_model.frame(j ? `SFFRP_OP_QIO4 : `SFFRP_OP_QIO, 1, a,
                               j ? 32 : 24, 2, 1, j ? 8'h20 : 8'h00, 4, 2, 4);
      for (int k = 0; k < 4; k++)
        chk("wrap data", pat(32'h100 + ((a[7:0] + k) % (j ? 64 : 8))),
            i_sffrp_host_model.rd[k]);
    end
    chk("cont", 8'h01, {7'h0, contReadActive});
    @(posedge clk) #1 resetCmd = 1;
    @(posedge clk) #1 resetCmd = 0;
    chk("cont", 8'h00, {7'h0, contReadActive});
  endtask
  task t_busy;
    @(posedge clk) #1 writeBusy = 1;
    i_sffrp_host_model.frame(`SFFRP_OP_DTR, 1, 32'h0, 24, 2, 1, 8'h00,
                             12, 2, 2);
    chk("busy oe", 8'h00, {4'h0, i_sffrp_host_model.seenOe});
    @(posedge clk) #1 writeBusy = 0;
  endtask
  task results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    rstn = 0;
    fourByteMode = 0;
    writeBusy = 0;
    resetCmd = 0;
    wrapLoad = 0;
    wrapCfgIn = 3'h1;
    memReqReady = 0;
    memRspValid = 0;
    memRspData = 8'h00;
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    repeat (6) @(posedge clk);
    t_outs;
    t_dio;
    t_qio;
    t_busy;
    results;
  end
  // a hung frame must not stall the run
  initial begin
    #500000;
    fails++;
    results;
  end
endmodule
